// >>> src/adc_cfg_map.vh
// register offsets, field positions, reset values and sample timing for the adc config block
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

// register byte addresses
`define OFS_CONFIG_ONE       8'h08
`define OFS_CONFIG_TWO       8'h0C
`define OFS_CONV_STATUS      8'h10

// first configuration register fields
`define FIRST_CONFIG_REGISTER_CLKSRC_LSB      0
`define FIRST_CONFIG_REGISTER_LSMP_BIT        4
`define FIRST_CONFIG_REGISTER_WMASK           32'h0000001F
`define FIRST_CONFIG_REGISTER_RESET           32'h00000000
`define CLKSRC_ASYNC         2'h3

// second configuration register fields
`define SECOND_CONFIG_REGISTER_LSTS_LSB        0
`define SECOND_CONFIG_REGISTER_HSC_BIT         2
`define SECOND_CONFIG_REGISTER_ACK_BIT         3
`define SECOND_CONFIG_REGISTER_MUX_BIT         4
`define SECOND_CONFIG_REGISTER_WMASK           32'h0000001F
`define SECOND_CONFIG_REGISTER_RESET           32'h00000000

// sample phase lengths in conversion clock cycles
`define SAMPLE_SHORT         5'h04
`define SAMPLE_EXTRA_00      5'h14
`define SAMPLE_EXTRA_01      5'h0C
`define SAMPLE_EXTRA_10      5'h06
`define SAMPLE_EXTRA_11      5'h02
`define HSC_EXTRA            5'h02

// axi response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// >>> src/sample_time_decode.v
// decodes the sample phase length and conversion overhead from configuration fields
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_map.vh"

module sample_time_decode (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       long_sample_mode,
  input  wire [1:0] long_sample_length,
  input  wire       high_speed_sequence,
  output reg  [4:0] sample_cycles,
  output reg  [4:0] sequence_extra_cycles
);

  reg [4:0] extra;

  // ==========================================
  // encoding to extra cycles
  always @* begin
    case (long_sample_length)
      2'h0:    extra = `SAMPLE_EXTRA_00;
      2'h1:    extra = `SAMPLE_EXTRA_01;
      2'h2:    extra = `SAMPLE_EXTRA_10;
      default: extra = `SAMPLE_EXTRA_11;
    endcase
  end

  // ==========================================
  // registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      sample_cycles         <= `SAMPLE_SHORT;
      sequence_extra_cycles <= 5'h00;
    end else begin
      sample_cycles         <= long_sample_mode ? (`SAMPLE_SHORT + extra)
                                                : `SAMPLE_SHORT;
      sequence_extra_cycles <= high_speed_sequence ? `HSC_EXTRA : 5'h00;
    end
  end

endmodule
`default_nettype wire

// >>> src/adc_config_two_regs.v
// axi4-lite register slave holding the two adc configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_map.vh"

// Function
// - reserved bits 31 to 8 and 7 to 5 of the second configuration register read as zero.
// - channel bank select clear routes the mux to bank a, set routes it to bank b.
// - async clock force set runs the async clock and its output always, whatever the state.
// - with force clear the async clock runs only when selected and a conversion is active.
// - high speed sequence set adds two conversion clock cycles to the conversion.
// - the long sample length field applies only while long sample mode is set.
// - length code 00 gives 20 extra cycles, 24 in total, the default.
// - length code 01 gives 12 extra cycles, 16 in total.
// - length code 10 gives 6 extra cycles, 10 in total.
// - length code 11 gives 2 extra cycles, 6 in total.
// - long sample mode set makes the length field effective, clear gives the short time.
// - clock source code 11 selects the async clock as conversion clock.
module adc_config_two_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        conversion_active,
  output reg         channel_bank_select,
  output reg         async_clock_enable,
  output reg         async_clock_out_enable,
  output reg  [1:0]  conversion_clock_source,
  output wire [4:0]  sample_cycles,
  output wire [4:0]  sequence_extra_cycles
);

  reg  [31:0] first_config_register_q;
  reg  [31:0] second_config_register_q;
  reg  [7:0]  awaddr_q;
  reg         aw_held_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_held_q;
  reg         conv_meta_q;
  reg         conv_sync_q;
  wire [31:0] strb_mask;
  wire        do_write;
  wire        async_selected;
  wire        force_on;
  reg  [31:0] rd_value;
  reg         rd_hit;
  reg  [31:0] first_config_register_d;
  reg  [31:0] second_config_register_d;
  reg  [7:0]  awaddr_d;
  reg         aw_held_d;
  reg  [31:0] wdata_d;
  reg  [3:0]  wstrb_d;
  reg         w_held_d;
  reg         bvalid_d;
  reg  [1:0]  bresp_d;
  reg         rvalid_d;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;
  reg         bank_d;
  reg         async_run_d;
  reg         async_out_d;
  reg  [1:0]  clock_source_d;
  wire [7:0]  wr_word_addr;
  wire [7:0]  rd_word_addr;
  wire [31:0] first_config_register_merged;
  wire [31:0] second_config_register_merged;
  wire [1:0]  clock_source_field;
  wire        long_mode_field;
  wire [1:0]  length_field;
  wire        high_speed_field;
  wire        bank_field;
  wire        aw_take;
  wire        w_take;
  wire        b_done;
  wire        ar_take;
  wire        r_done;
  wire [31:0] first_config_register_view;
  wire [31:0] second_config_register_view;
  wire [31:0] status_view;

  // ==========================================
  // conversion active synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_meta_q <= 1'b0;
      conv_sync_q <= 1'b0;
    end else begin
      conv_meta_q <= conversion_active;
      conv_sync_q <= conv_meta_q;
    end
  end

  // ==========================================
  // write channel capture
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write      = aw_held_q && w_held_q;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_strb
      assign strb_mask[8*g+7:8*g] = {8{wstrb_q[g]}};
    end
  endgenerate

  // ==========================================
  // channel handshakes
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign b_done  = s_axi_bvalid && s_axi_bready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done  = s_axi_rvalid && s_axi_rready;

  assign wr_word_addr = {awaddr_q[7:2], 2'b00};
  assign first_config_register_merged  = (first_config_register_q & ~(strb_mask & `FIRST_CONFIG_REGISTER_WMASK))
                      | (wdata_q & strb_mask & `FIRST_CONFIG_REGISTER_WMASK);
  assign second_config_register_merged  = (second_config_register_q & ~(strb_mask & `SECOND_CONFIG_REGISTER_WMASK))
                      | (wdata_q & strb_mask & `SECOND_CONFIG_REGISTER_WMASK);

  // ==========================================
  // write next state
  always @* begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    first_config_register_d    = first_config_register_q;
    second_config_register_d    = second_config_register_q;
    if (aw_take) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (wr_word_addr)
        `OFS_CONFIG_ONE: begin
          first_config_register_d = first_config_register_merged;
        end
        `OFS_CONFIG_TWO: begin
          second_config_register_d = second_config_register_merged;
        end
        `OFS_CONV_STATUS: begin
          bresp_d = `RESP_OKAY;
        end
        default: begin
          bresp_d = `RESP_SLVERR;
        end
      endcase
    end else if (b_done) begin
      bvalid_d = 1'b0;
    end
  end

  // ==========================================
  // write registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      first_config_register_q       <= `FIRST_CONFIG_REGISTER_RESET;
      second_config_register_q       <= `SECOND_CONFIG_REGISTER_RESET;
    end else begin
      aw_held_q    <= aw_held_d;
      w_held_q     <= w_held_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb_q      <= wstrb_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp  <= bresp_d;
      first_config_register_q       <= first_config_register_d;
      second_config_register_q       <= second_config_register_d;
    end
  end

  // ==========================================
  // register read views
  assign first_config_register_view   = first_config_register_q & `FIRST_CONFIG_REGISTER_WMASK;
  assign second_config_register_view   = second_config_register_q & `SECOND_CONFIG_REGISTER_WMASK;
  assign status_view = {30'h0, async_clock_enable, conv_sync_q};

  // ==========================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_word_addr  = {s_axi_araddr[7:2], 2'b00};

  always @* begin
    rd_value = 32'h00000000;
    rd_hit   = 1'b1;
    case (rd_word_addr)
      `OFS_CONFIG_ONE: begin
        rd_value = first_config_register_view;
      end
      `OFS_CONFIG_TWO: begin
        rd_value = second_config_register_view;
      end
      `OFS_CONV_STATUS: begin
        rd_value = status_view;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ==========================================
  // read next state
  always @* begin
    rvalid_d = s_axi_rvalid;
    rdata_d  = s_axi_rdata;
    rresp_d  = s_axi_rresp;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_value;
      rresp_d  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      rvalid_d = 1'b0;
    end
  end

  // ==========================================
  // read registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rresp_d;
    end
  end

  // ==========================================
  // configuration field taps
  assign clock_source_field = first_config_register_q[`FIRST_CONFIG_REGISTER_CLKSRC_LSB+1:`FIRST_CONFIG_REGISTER_CLKSRC_LSB];
  assign long_mode_field    = first_config_register_q[`FIRST_CONFIG_REGISTER_LSMP_BIT];
  assign length_field       = second_config_register_q[`SECOND_CONFIG_REGISTER_LSTS_LSB+1:`SECOND_CONFIG_REGISTER_LSTS_LSB];
  assign high_speed_field   = second_config_register_q[`SECOND_CONFIG_REGISTER_HSC_BIT];
  assign bank_field         = second_config_register_q[`SECOND_CONFIG_REGISTER_MUX_BIT];
  assign force_on           = second_config_register_q[`SECOND_CONFIG_REGISTER_ACK_BIT];
  assign async_selected     = (clock_source_field == `CLKSRC_ASYNC);

  // ==========================================
  // converter control next state
  always @* begin
    bank_d         = bank_field;
    async_out_d    = force_on;
    async_run_d    = force_on || (async_selected && conv_sync_q);
    clock_source_d = clock_source_field;
  end

  // ==========================================
  // converter control outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_bank_select     <= 1'b0;
      async_clock_enable      <= 1'b0;
      async_clock_out_enable  <= 1'b0;
      conversion_clock_source <= 2'h0;
    end else begin
      channel_bank_select     <= bank_d;
      async_clock_enable      <= async_run_d;
      async_clock_out_enable  <= async_out_d;
      conversion_clock_source <= clock_source_d;
    end
  end

  // ==========================================
  // sample phase and sequence timing
  sample_time_decode u_sample_time_decode (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .long_sample_mode      (long_mode_field),
    .long_sample_length    (length_field),
    .high_speed_sequence   (high_speed_field),
    .sample_cycles         (sample_cycles),
    .sequence_extra_cycles (sequence_extra_cycles)
  );

endmodule
`default_nettype wire

// >>> sim/adc_cfg_props.sv
// assertions on the adc configuration register slave ports
`timescale 1ns/1ns
`default_nettype none
module adc_cfg_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conversion_active,
  input wire logic        async_clock_enable,
  input wire logic        async_clock_out_enable,
  input wire logic [1:0]  conversion_clock_source,
  input wire logic [4:0]  sample_cycles,
  input wire logic [4:0]  sequence_extra_cycles
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // properties
  chk_seq_extra: assert property (sequence_extra_cycles inside {5'h00, 5'h02})
    else $error("extra cycles off");
  chk_sample_set: assert property (
    sample_cycles inside {5'h04, 5'h18, 5'h10, 5'h0A, 5'h06})
    else $error("sample length off");
  chk_force_runs: assert property (async_clock_out_enable |-> async_clock_enable)
    else $error("forced clock idle");
  chk_async_sel: assert property (
    async_clock_enable && !async_clock_out_enable |->
    conversion_clock_source == 2'h3 || $past(conversion_clock_source) == 2'h3)
    else $error("async clock unselected");
  chk_async_gate: assert property (
    async_clock_enable && !async_clock_out_enable |-> $past(conversion_active, 3))
    else $error("async clock without conversion");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_resv_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C |=> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved bits set");
  cover property (async_clock_out_enable);
  cover property (sample_cycles == 5'h06);
  cover property (sequence_extra_cycles == 5'h02);
endmodule
bind adc_config_two_regs adc_cfg_props chk_i (.*);
`default_nettype wire

// >>> sim/test_adc_config2_sample_clock.sv
// self-checking bench for the adc configuration register slave
`timescale 1ns/1ns
`default_nettype none
module test_adc_config2_sample_clock;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, act = 1'b0;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid, bank, aen, aoe;
  wire  [1:0]  bresp, rresp, src;
  wire  [31:0] rdata;
  wire  [4:0]  smp, ext;
  int          fail_count = 0, checks_done = 0;
  adc_config_two_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conversion_active(act), .channel_bank_select(bank), .async_clock_enable(aen),
    .async_clock_out_enable(aoe), .conversion_clock_source(src), .sample_cycles(smp),
    .sequence_extra_cycles(ext));
  always #50 aclk = ~aclk;
  // ==========================================
  // shared tasks
  task automatic stop_test;
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 40) begin
        fail_count++;
        $display("[ERR] bvalid exp 1 got 0");
        stop_test;
      end
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 40) begin
        fail_count++;
        $display("[ERR] rvalid exp 1 got 0");
        stop_test;
      end
    end while (!(rvalid && rready));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rd_reg(8'h0C);
    chk("second_config_register reset", 32'h0, rd);
    chk("short sample", 32'h4, {27'h0, smp});
  endtask
  task automatic t_lengths;
    logic [4:0] e[4] = '{5'h18, 5'h10, 5'h0A, 5'h06};
    wr(8'h08, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, i);
      chk("long sample", {27'h0, e[i]}, {27'h0, smp});
    end
    wr(8'h08, 32'h0);
    chk("code ignored", 32'h4, {27'h0, smp});
  endtask
  task automatic t_bits;
    wr(8'h0C, 32'h14);
    chk("bank b", 32'h1, {31'h0, bank});
    chk("hs extra", 32'h2, {27'h0, ext});
    wr(8'h0C, 32'h0);
    chk("bank a", 32'h0, {31'h0, bank});
    chk("normal seq", 32'h0, {27'h0, ext});
  endtask
  task automatic t_clock;
    wr(8'h0C, 32'h8);
    chk("forced out", 32'h1, {31'h0, aoe});
    chk("forced run", 32'h1, {31'h0, aen});
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h3);
    chk("clock source", 32'h3, {30'h0, src});
    chk("async idle", 32'h0, {31'h0, aen});
    act <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("async run", 32'h1, {31'h0, aen});
    rd_reg(8'h10);
    chk("status read", 32'h3, rd);
    wr(8'h08, 32'h0);
    repeat (3) @(posedge aclk);
    chk("async stop", 32'h0, {31'h0, aen});
    act <= 1'b0;
  endtask
  task automatic t_resv;
    wr(8'h0C, 32'hFFFFFFFF);
    chk("write resp", 32'h0, {30'h0, rs});
    rd_reg(8'h0C);
    chk("reserved read", 32'h1F, rd);
    wstrb <= 4'hE;
    wr(8'h0C, 32'h0);
    rd_reg(8'h0C);
    chk("lane off", 32'h1F, rd);
    wstrb <= 4'hF;
    wr(8'h08, 32'hFFFFFFFF);
    rd_reg(8'h08);
    chk("first_config_register read", 32'h1F, rd);
    rd_reg(8'h40);
    chk("unmapped resp", 32'h2, {30'h0, rs});
  endtask
  task automatic t_midreset;
    act <= 1'b0;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset bank", 32'h0, {31'h0, bank});
    chk("reset source", 32'h0, {30'h0, src});
    chk("reset sample", 32'h4, {27'h0, smp});
    rd_reg(8'h0C);
    chk("second_config_register after reset", 32'h0, rd);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_lengths;
    t_bits;
    t_clock;
    t_resv;
    t_midreset;
    stop_test;
  end
endmodule
`default_nettype wire
